/* File: hdl/ee_i2c_slave.sv */
// Two-wire slave protocol engine of the 256-byte serial EEPROM
`timescale 1ns/1ps

// Contract
// - Receiver pulls data low on ninth clock
// - Acknowledge only own address after START
// - Acknowledge every byte once write-selected
// - Read: send eight bits, sample master ack
// - Master no-ack: release, wait for STOP
// - STOP after write starts programming, ignores requests
// - Write increments only in-page address bits
// - Over sixteen bytes wrap and overwrite
// - All page bytes programmed in one cycle
// - No address ack while programming; polling
// - Counter holds last accessed address plus one
// - Counter wraps from 255 to zero
// - Current read: one byte, no-ack, STOP
// - Sequential read increments all address bits
// - Address upper nibble 1010, full match
// - Address bit zero one means read
module ee_i2c_slave
  import ee_pkg::*;
#(
  parameter int P_WR_CYC = ee_pkg::EE_WR_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  output logic      o_busy
);

  ee_mem_if          mem ();

  ee_state_t         state_r;
  ee_state_t         after_ack_r;
  logic [3:0]        cnt_r;
  logic [7:0]        shift_r;
  logic              oe_r;
  logic              mack_r;
  logic              wrote_r;
  logic [EE_AW-1:0]  addr_r;
  logic              scl_q;
  logic              sda_q;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;
  logic              rx_state;
  logic              byte_done;
  logic              addr_ok;
  logic              rd_end;

  // ==========================================================================
  // In-page increment: high bits held, low bits wrap
  function automatic logic [EE_AW-1:0] page_inc(input logic [EE_AW-1:0] a);
    page_inc = {a[EE_AW-1:EE_PW], a[EE_PW-1:0] + 1'b1};
  endfunction

  // ==========================================================================
  // Bus conditions
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign scl_rise  = i_scl && !scl_q;
  assign scl_fall  = !i_scl && scl_q;
  assign start_c   = i_scl && scl_q && sda_q && !i_sda;
  assign stop_c    = i_scl && scl_q && !sda_q && i_sda;
  assign rx_state  = (state_r == EE_SADDR) || (state_r == EE_WADDR) ||
                     (state_r == EE_WDATA);
  assign byte_done = rx_state && scl_fall && (cnt_r == EE_BITS);
  // Busy refuses both directions; a read could see stale array data
  assign addr_ok   = (shift_r[7:1] == EE_SLV_ADDR) && !mem.busy;
  assign rd_end    = (state_r == EE_RDATA) && scl_fall && (cnt_r == EE_BITS);

  // ==========================================================================
  // Protocol state machine
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r     <= EE_IDLE;
      after_ack_r <= EE_IDLE;
      cnt_r       <= '0;
      shift_r     <= '0;
      oe_r        <= 1'b0;
      mack_r      <= 1'b0;
    end else if (start_c) begin
      state_r <= EE_SADDR;
      cnt_r   <= '0;
      oe_r    <= 1'b0;
    end else if (stop_c) begin
      state_r <= EE_IDLE;
      oe_r    <= 1'b0;
    end else begin
      case (state_r)
        EE_SADDR, EE_WADDR, EE_WDATA: begin
          if (scl_rise && cnt_r != EE_BITS) begin
            shift_r <= {shift_r[6:0], i_sda};
            cnt_r   <= cnt_r + 1'b1;
          end else if (byte_done) begin
            cnt_r <= '0;
            if (state_r != EE_SADDR) begin
              oe_r        <= 1'b1;
              state_r     <= EE_ACK;
              after_ack_r <= EE_WDATA;
            end else if (addr_ok) begin
              oe_r    <= 1'b1;
              state_r <= EE_ACK;
              if (shift_r[0] == EE_DIR_RD) begin
                after_ack_r <= EE_RDATA;
              end else begin
                after_ack_r <= EE_WADDR;
              end
            end else begin
              state_r <= EE_WAIT;
            end
          end
        end
        EE_ACK: begin
          if (scl_fall) begin
            state_r <= after_ack_r;
            cnt_r   <= '0;
            if (after_ack_r == EE_RDATA) begin
              shift_r <= mem.rd_data;
              oe_r    <= !mem.rd_data[7];
            end else begin
              oe_r <= 1'b0;
            end
          end
        end
        EE_RDATA: begin
          if (scl_rise && cnt_r != EE_BITS) begin
            cnt_r <= cnt_r + 1'b1;
          end else if (rd_end) begin
            oe_r    <= 1'b0;
            state_r <= EE_RACK;
          end else if (scl_fall) begin
            shift_r <= {shift_r[6:0], 1'b0};
            oe_r    <= !shift_r[6];
          end
        end
        EE_RACK: begin
          if (scl_rise) begin
            mack_r <= !i_sda;
          end else if (scl_fall) begin
            cnt_r <= '0;
            if (mack_r) begin
              state_r <= EE_RDATA;
              shift_r <= mem.rd_data;
              oe_r    <= !mem.rd_data[7];
            end else begin
              state_r <= EE_WAIT;
            end
          end
        end
        EE_IDLE, EE_WAIT: begin
          oe_r <= 1'b0;
        end
        default: begin
          state_r <= EE_IDLE;
          oe_r    <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Address counter: read advances all bits, write only the page offset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_r <= '0;
    end else if (byte_done && state_r == EE_WADDR) begin
      addr_r <= shift_r;
    end else if (byte_done && state_r == EE_WDATA) begin
      addr_r <= page_inc(addr_r);
    end else if (rd_end) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  // A write ends only at a byte boundary; a partial byte discards it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wrote_r <= 1'b0;
    end else if (start_c || stop_c) begin
      wrote_r <= 1'b0;
    end else if (byte_done && state_r == EE_WDATA) begin
      wrote_r <= 1'b1;
    end
  end

  assign mem.rd_addr  = addr_r;
  assign mem.buf_clr  = start_c;
  assign mem.buf_we   = byte_done && (state_r == EE_WDATA);
  assign mem.buf_addr = addr_r;
  assign mem.buf_data = shift_r;
  // The clock rise ahead of a STOP is taken as one bit, so a STOP on a
  // byte boundary always arrives with exactly one bit counted
  assign mem.commit   = stop_c && wrote_r && (state_r == EE_WDATA) &&
                        (cnt_r == 4'h1);

  ee_array #(
    .P_WR_CYC (P_WR_CYC)
  ) u_array (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .mem      (mem)
  );

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = oe_r;
  assign o_busy    = mem.busy;

endmodule

/* File: inc/ee_pkg.sv */
// Shared constants and types for the serial EEPROM slave front end
package ee_pkg;

  // ==========================================================================
  // Array geometry
  localparam int        EE_DEPTH     = 256;
  localparam int        EE_AW        = 8;
  localparam int        EE_PAGE      = 16;
  localparam int        EE_PW        = 4;
  localparam logic [7:0] EE_ERASED   = 8'hff;

  // ==========================================================================
  // Bus addressing: upper nibble 1010, lower bits zero, bit 0 is direction
  localparam logic [6:0] EE_SLV_ADDR = 7'h50;
  localparam logic       EE_DIR_RD   = 1'h1;
  localparam logic [3:0] EE_BITS     = 4'h8;

  // ==========================================================================
  // Timing: internal programming cycle
  localparam int        EE_CLK_MHZ   = 25;
  localparam int        EE_T_WR_US   = 5000;
  localparam int        EE_WR_CYC    = EE_T_WR_US * EE_CLK_MHZ;
  localparam int        EE_TW        = 20;

  // ==========================================================================
  // Protocol states
  typedef enum logic [7:0] {
    EE_IDLE  = 8'h01,
    EE_SADDR = 8'h02,
    EE_WADDR = 8'h04,
    EE_WDATA = 8'h08,
    EE_ACK   = 8'h10,
    EE_RDATA = 8'h20,
    EE_RACK  = 8'h40,
    EE_WAIT  = 8'h80
  } ee_state_t;

endpackage

/* File: inc/ee_mem_if.sv */
// Carrier between protocol engine and storage array
`timescale 1ns/1ps
interface ee_mem_if;
  import ee_pkg::*;
  logic [EE_AW-1:0] rd_addr;
  logic [7:0]       rd_data;
  logic             buf_clr;
  logic             buf_we;
  logic [EE_AW-1:0] buf_addr;
  logic [7:0]       buf_data;
  logic             commit;
  logic             busy;

  modport ctl (output rd_addr, buf_clr, buf_we, buf_addr, buf_data, commit,
               input  rd_data, busy);
  modport arr (input  rd_addr, buf_clr, buf_we, buf_addr, buf_data, commit,
               output rd_data, busy);
endinterface

/* File: hdl/ee_array.sv */
// Storage array, page buffer and programming cycle timer
`timescale 1ns/1ps
module ee_array
  import ee_pkg::*;
#(
  parameter int P_WR_CYC = EE_WR_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  ee_mem_if.arr     mem
);

  logic [7:0]          mem_r   [EE_DEPTH];
  logic [7:0]          pbuf_r  [EE_PAGE];
  logic [EE_PAGE-1:0]  pvalid_r;
  logic [EE_PW-1:0]    page_r;
  logic [EE_TW-1:0]    tmr_r;
  logic                busy_r;
  logic                done;

  assign done        = busy_r && (tmr_r == EE_TW'(P_WR_CYC - 1));
  assign mem.busy    = busy_r;
  assign mem.rd_data = mem_r[mem.rd_addr];

  // ==========================================================================
  // Page buffer: later bytes at the same offset replace earlier ones
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pvalid_r <= '0;
      page_r   <= '0;
      for (int i = 0; i < EE_PAGE; i++) begin
        pbuf_r[i] <= EE_ERASED;
      end
    // Polling STARTs during programming must not drop the pending page
    end else if ((mem.buf_clr && !busy_r) || done) begin
      pvalid_r <= '0;
    end else if (mem.buf_we) begin
      pbuf_r[mem.buf_addr[EE_PW-1:0]]   <= mem.buf_data;
      pvalid_r[mem.buf_addr[EE_PW-1:0]] <= 1'b1;
      page_r <= mem.buf_addr[EE_AW-1:EE_PW];
    end
  end

  // ==========================================================================
  // Programming cycle: every buffered byte of the page lands at once when the timer expires
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_r <= 1'b0;
      tmr_r  <= '0;
    end else if (mem.commit && !busy_r) begin
      busy_r <= 1'b1;
      tmr_r  <= '0;
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < EE_DEPTH; i++) begin
        mem_r[i] <= EE_ERASED;
      end
    end else if (done) begin
      for (int i = 0; i < EE_PAGE; i++) begin
        if (pvalid_r[i]) begin
          mem_r[{page_r, EE_PW'(i)}] <= pbuf_r[i];
        end
      end
    end
  end

endmodule

/* File: testbench/ee_i2c_slave_assertions.sv */
// Pin-level checks on the EEPROM slave
`timescale 1ns/1ps
module ee_i2c_slave_assertions #(
  parameter int P_WR_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  logic        scl_r;
  logic        sda_r;
  logic [31:0] cnt_r;
  wire         start_c = scl_r & i_scl & sda_r & ~i_sda;
  wire         stop_c  = scl_r & i_scl & ~sda_r & i_sda;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_r <= 1'h1;
      sda_r <= 1'h1;
      cnt_r <= 32'h0;
    end else begin
      scl_r <= i_scl;
      sda_r <= i_sda;
      cnt_r <= o_busy ? cnt_r + 32'h1 : 32'h0;
    end
  end

  // ==========
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_drive_zero: assert property (o_sda_out == 1'h0)
    else $error("data value not low");
  chk_busy_cause: assert property ($rose(o_busy) |-> $past(stop_c))
    else $error("busy without stop");
  chk_busy_span: assert property ($fell(o_busy) |->
    cnt_r >= P_WR_CYC && cnt_r <= P_WR_CYC + 1)
    else $error("busy span wrong");
  chk_quiet_busy: assert property ($rose(o_sda_oe) |-> !$past(o_busy))
    else $error("drive while busy");
  chk_oe_scl_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
    else $error("data moved with clock high");
  chk_stop_idle: assert property (stop_c |-> ##1 !o_sda_oe [*2])
    else $error("drive after stop");
  chk_start_rel: assert property (start_c |=> !o_sda_oe)
    else $error("drive after start");
  chk_drive_end: assert property ($rose(o_sda_oe) |->
    ##[1:100] $fell(o_sda_oe))
    else $error("drive held too long");
endmodule

bind ee_i2c_slave ee_i2c_slave_assertions #(.P_WR_CYC(P_WR_CYC)) chk_i (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_busy(o_busy));

/* File: testbench/ee_bus_master.sv */
// Bus master model: clock and open-drain data line
`timescale 1ns/1ps
module ee_bus_master (
  input  wire logic i_clk,
  input  wire logic i_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic drv_r = 1'h1;
  // Pull-up: a released line reads high
  assign o_sda = drv_r & ~i_oe;
  initial o_scl = 1'h1;

  // ==========
  // Bus tasks
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic start();
    w(1);
    drv_r = 1'h1;
    w(2);
    o_scl = 1'h1;
    w(3);
    drv_r = 1'h0;
    w(3);
    o_scl = 1'h0;
  endtask
  task automatic stop();
    w(1);
    drv_r = 1'h0;
    w(2);
    o_scl = 1'h1;
    w(3);
    drv_r = 1'h1;
    w(3);
  endtask
  // MSB first; bit 0 is the acknowledge slot; n cuts a byte short
  task automatic xfer(input logic [8:0] d, output logic [8:0] q,
                      input int n = 9);
    q = 9'h1ff;
    for (int i = 8; i > 8 - n; i--) begin
      w(1);
      drv_r = d[i];
      w(2);
      o_scl = 1'h1;
      w(4);
      q[i] = o_sda;
      o_scl = 1'h0;
    end
  endtask
endmodule

/* File: testbench/ee_i2c_slave_test.sv */
// Self-checking bench for the EEPROM slave
`timescale 1ns/1ps
module ee_i2c_slave_test;
  import ee_pkg::*;
  localparam int P_WR = 200;
  logic       clk = 1'h0;
  logic       arst_n = 1'h0;
  logic       scl;
  logic       sda;
  logic       oe;
  logic       busy;
  logic [8:0] q;
  int         err_count = 0;
  int         samples_checked = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end

  initial forever #20 clk = ~clk;
  ee_i2c_slave #(.P_WR_CYC(P_WR)) ee_i2c_slave_i (
    .i_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(), .o_sda_oe(oe), .o_busy(busy));
  ee_bus_master ee_bus_master_i (
    .i_clk(clk), .i_oe(oe), .o_scl(scl), .o_sda(sda));

  // ==========
  // Scenarios
  // Page 0x30 got 0x40.. from offset 0xc; two extra bytes wrapped
  function automatic logic [7:0] exp_at(input logic [7:0] a);
    logic [3:0] o;
    o = a[3:0] - 4'hc;
    if (a == 8'hff)
      return 8'h5a;
    if (a[7:4] != 4'h3)
      return EE_ERASED;
    return (o < 4'h2) ? 8'h50 + 8'(o) : 8'h40 + 8'(o);
  endfunction
  task automatic sel(input logic [7:0] a);
    ee_bus_master_i.start();
    ee_bus_master_i.xfer({a, 1'h1}, q);
  endtask
  task automatic wr(input logic [7:0] b);
    ee_bus_master_i.xfer({b, 1'h1}, q);
    `CHK(q[0], 1'h0)
  endtask
  task automatic poll();
    sel(8'ha0);
    `CHK(q[0], 1'h1)
    for (int k = 0; k < 20 && q[0]; k++)
      sel(8'ha0);
    `CHK(q[0], 1'h0)
    ee_bus_master_i.stop();
  endtask
  task automatic t_bad();
    sel(8'hb0);
    `CHK(q[0], 1'h1)
    sel(8'ha2);
    `CHK(q[0], 1'h1)
    ee_bus_master_i.stop();
  endtask
  task automatic t_page();
    sel(8'ha0);
    `CHK(q[0], 1'h0)
    wr(8'h3c);
    for (int i = 0; i < 18; i++)
      wr(8'h40 + 8'(i));
    ee_bus_master_i.stop();
    `CHK(busy, 1'h1)
    poll();
  endtask
  task automatic t_abort();
    sel(8'ha0);
    wr(8'h30);
    ee_bus_master_i.xfer(9'h0, q, 4);
    ee_bus_master_i.stop();
    `CHK(busy, 1'h0)
  endtask
  task automatic t_read(input logic [7:0] a, input int n);
    sel(8'ha0);
    wr(a);
    sel(8'ha1);
    `CHK(q[0], 1'h0)
    for (int i = 0; i < n; i++) begin
      ee_bus_master_i.xfer({8'hff, i == n - 1}, q);
      `CHK(q[8:1], exp_at(a + 8'(i)))
    end
    ee_bus_master_i.stop();
  endtask
  task automatic t_cur(input logic [7:0] e);
    sel(8'ha1);
    ee_bus_master_i.xfer(9'h1ff, q);
    `CHK(q[8:1], e)
    ee_bus_master_i.xfer(9'h1ff, q);
    `CHK(q, 9'h1ff)
    ee_bus_master_i.stop();
  endtask
  task automatic t_wrap();
    sel(8'ha0);
    wr(8'hff);
    wr(8'h5a);
    ee_bus_master_i.stop();
    poll();
    t_read(8'hff, 2);
  endtask

  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'h1;
    `CHK({oe, busy}, 2'h0)
    ee_bus_master_i.w(2);
    t_bad();
    t_page();
    t_abort();
    t_read(8'h3c, 6);
    t_read(8'h38, 4);
    t_cur(8'h50);
    t_wrap();
    stop_test();
  end
  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule
